// ### logic/hp_regs.svh
`ifndef HP_REGS_SVH
`define HP_REGS_SVH

// device register offsets on the host port
`define HP_REG_STAT 8'h00
`define HP_REG_MASK 8'h01
`define HP_REG_CTRL 8'h02
`define HP_REG_MIDX 8'h03
`define HP_REG_MDATA 8'h04
`define HP_CTRL_IDLE_DRV 0
`define HP_MAC_IDX_W 3
`define HP_MAC_N 8

// bus mode strap encodings
`define HP_MODE_SEP 2'b00
`define HP_MODE_DS 2'b01
`define HP_MODE_EEP 2'b10

// serial eeprom load
`define HP_EE_READ 8'h03
`define HP_EE_READ_MASK 8'hF7
`define HP_EE_START 8'h00
`define HP_CFG_LEN 64
`define HP_MAC_PAIRS 4
`define HP_HDR_BITS 16
`define HP_TOTAL_BITS (`HP_HDR_BITS + 8 * (`HP_CFG_LEN + 2 * `HP_MAC_PAIRS))

// timing at sys_clk
`define HP_SYS_KHZ 200000
`define HP_SCK_KHZ 8330
`define HP_SCK_HALF (`HP_SYS_KHZ / (2 * `HP_SCK_KHZ))
`define HP_LOAD_MS 5
`define HP_LOAD_CYC (`HP_LOAD_MS * `HP_SYS_KHZ)

// controller side
`define HC_STROBE_CYC 4
`define HC_REG_ADDR 8'h00
`define HC_REG_WDATA 8'h01
`define HC_REG_GO 8'h02
`define HC_REG_STAT 8'h03
`define HC_REG_RDATA 8'h04
`define HC_REG_PINS 8'h05
`define HC_IMG_BASE 8'h10
`define HC_IMG_N 16
`define HC_PINS_RST 5'h10

`endif

// ### logic/hp_pkg.sv
package hp_pkg;
  `include "hp_regs.svh"

  typedef enum logic [1:0] {HP_IDLE, HP_LOAD} hp_load_t;

  typedef struct packed {
    logic [255:0][7:0] regs;
    logic [`HP_MAC_N-1:0][7:0] mac;
    logic [`HP_MAC_IDX_W-1:0] mtmp;
    logic [7:0] rd_data;
    logic d_oe;
    logic irq_n;
    logic irq_oe;
    logic strb_d;
    logic acc_rd;
    logic [7:0] acc_addr;
    logic ext_rst_d;
    logic boot;
    hp_load_t st;
    logic [4:0] div;
    logic sck;
    logic mosi;
    logic cs_n;
    logic [15:0] osr;
    logic [7:0] isr;
    logic [9:0] bitcnt;
    logic [20:0] wd;
  } hp_dev_t;

  typedef enum logic [1:0] {HC_IDLE, HC_SETUP, HC_STRB, HC_HOLD} hp_bus_t;

  typedef struct packed {
    hp_bus_t st;
    logic [2:0] cnt;
    logic is_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] pins;
    logic [7:0] u_rdata;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ds_n;
    logic rw;
    logic d_oe;
    logic [`HC_IMG_N-1:0][7:0] img;
    logic sck_d;
    logic [9:0] bcnt;
    logic [7:0] ish;
    logic cmd_ok;
    logic miso;
  } hp_host_t;
endpackage

// ### logic/hp_if.sv
`timescale 1ns/100ps
interface hp_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic data_strobe_n;
  logic rd_wr;
  logic [7:0] addr;
  logic [7:0] d_host;
  logic d_host_oe;
  logic [7:0] d_dev;
  logic d_dev_oe;
  logic irq_n_o;
  logic irq_oe;
  logic [1:0] bus_mode_select;
  logic hardware_mode_pin;
  logic spi_edge_select;
  logic ext_rst_n;
  logic spi_cs_n;
  logic eeprom_clock;
  logic mosi;
  logic miso;

  modport dev (
    input cs_n, rd_n, wr_n, data_strobe_n, rd_wr, addr, d_host, d_host_oe,
    input bus_mode_select, hardware_mode_pin, spi_edge_select, ext_rst_n, miso,
    output d_dev, d_dev_oe, irq_n_o, irq_oe, spi_cs_n, eeprom_clock, mosi
  );
  modport host (
    output cs_n, rd_n, wr_n, data_strobe_n, rd_wr, addr, d_host, d_host_oe,
    output bus_mode_select, hardware_mode_pin, spi_edge_select, ext_rst_n, miso,
    input d_dev, d_dev_oe, irq_n_o, irq_oe, spi_cs_n, eeprom_clock, mosi
  );
endinterface

// ### logic/hp_dev.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
// Overview of operation
// (RL1) mode 00: separate low read/write strobes
// (RL2) mode 01: data strobe, direction high reads
// (RL3) 8-bit data, 8 separate address lines
// (RL4) no multiplexed address/data mode
// (RL5) chip select low; else strobes ignored
// (RL6) interrupt pin low while enabled source active
// (RL7) reading latched status clears it
// (RL8) event during clearing read stays latched; code keeps it only on the trailing-edge cycle, earlier ones clear unread
// (RL9) software handles all bits per read
// (RL10) drive-select bit: drive high or float idle
// (RL11) pin floats after reset until interrupt
// (RL12) eeprom mode: act as SPI master
// (RL13) load at reset and reset pin rise
// (RL14) edge select picks sample/update edges
// (RL15) eeprom clock 8.33 MHz from system clock
// (RL16) send read instruction then address zero
// (RL17) select low until last byte latched
// (RL18) MAC indirect registers written after others; code also writes mac[mtmp] with the address-phase byte before them
// (RL19) load finishes within 5 ms
// (RL20) shift most significant bit first
// (RL21) host accesses ignored while loading
`include "hp_regs.svh"
module hp_dev
  import hp_pkg::*;
#(
  parameter int LOAD_LIMIT_CYC = `HP_LOAD_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  hp_if.dev pins,
  input wire logic [7:0] evt_i,
  output logic load_busy_o,
  output logic irq_o
);

  localparam logic [4:0] SCK_HALF = 5'(`HP_SCK_HALF);
  localparam logic [9:0] TOTAL_BITS = 10'(`HP_TOTAL_BITS);
  localparam logic [20:0] LOAD_LIM = 21'(LOAD_LIMIT_CYC - 1);
  localparam logic [6:0] CFG_LEN = 7'(`HP_CFG_LEN);

  hp_dev_t s_ff;
  hp_dev_t nxt_s;

  logic sep_mode;
  logic ds_mode;
  logic strb;
  logic is_rd;
  logic rise;
  logic fall;
  logic upd;
  logic smp;
  logic irq_act;
  logic do_clr;
  logic start;
  logic finish;
  logic [7:0] byte_in;
  logic [6:0] k;
  logic [6:0] j;

  always_comb begin
    nxt_s = s_ff;
    rise = 1'b0;
    fall = 1'b0;
    upd = 1'b0;
    smp = 1'b0;
    do_clr = 1'b0;
    finish = 1'b0;
    byte_in = {s_ff.isr[6:0], pins.miso};
    k = 7'(s_ff.bitcnt[9:3]) - 7'h02;
    j = k - CFG_LEN;

    // host port: only the two strobe modes, never multiplexed
    sep_mode = !pins.hardware_mode_pin && pins.bus_mode_select == `HP_MODE_SEP; // RL1 RL4
    ds_mode = !pins.hardware_mode_pin && pins.bus_mode_select == `HP_MODE_DS; // RL2
    if (sep_mode) begin
      strb = !pins.rd_n || !pins.wr_n; // RL1
      is_rd = !pins.rd_n; // RL1
    end else begin
      strb = !pins.data_strobe_n; // RL2
      is_rd = pins.rd_wr; // RL2
    end
    // strobes outside chip select or during a load never start an access
    strb = strb && !pins.cs_n && (sep_mode || ds_mode) && s_ff.st == HP_IDLE; // RL5 RL21
    nxt_s.strb_d = strb;

    if (strb && !s_ff.strb_d) begin
      nxt_s.acc_addr = pins.addr; // RL3
      nxt_s.acc_rd = is_rd;
      if (is_rd) begin
        nxt_s.d_oe = 1'b1;
        if (pins.addr == `HP_REG_MDATA) begin
          nxt_s.rd_data = s_ff.mac[s_ff.regs[`HP_REG_MIDX][`HP_MAC_IDX_W-1:0]];
        end else begin
          nxt_s.rd_data = s_ff.regs[pins.addr]; // RL3
        end
      end
    end

    // reads take effect on their trailing edge so the host sees stable data
    if (!strb && s_ff.strb_d) begin
      nxt_s.d_oe = 1'b0;
      if (s_ff.acc_rd) begin
        do_clr = s_ff.acc_addr == `HP_REG_STAT; // RL7
      end else if (s_ff.acc_addr == `HP_REG_MDATA) begin
        nxt_s.mac[s_ff.regs[`HP_REG_MIDX][`HP_MAC_IDX_W-1:0]] = pins.d_host;
      end else if (s_ff.acc_addr != `HP_REG_STAT) begin
        nxt_s.regs[s_ff.acc_addr] = pins.d_host;
      end
    end

    // load start: first cycle after reset, or reset pin rising
    nxt_s.ext_rst_d = pins.ext_rst_n;
    nxt_s.boot = 1'b0;
    start = (s_ff.boot || (pins.ext_rst_n && !s_ff.ext_rst_d))
      && !pins.hardware_mode_pin && pins.bus_mode_select == `HP_MODE_EEP; // RL12 RL13
    if (start) begin
      nxt_s.st = HP_LOAD; // RL12
      nxt_s.cs_n = 1'b0; // RL17
      nxt_s.osr = {`HP_EE_READ, `HP_EE_START}; // RL16
      nxt_s.bitcnt = 10'h000;
      nxt_s.div = 5'h00;
      nxt_s.sck = 1'b0;
      nxt_s.wd = 21'h000000;
      // edge select low: first bit must be on MOSI before the first rising edge
      if (!pins.spi_edge_select) begin
        nxt_s.mosi = 1'(`HP_EE_READ >> 7); // RL14 RL20
        nxt_s.osr = {`HP_EE_READ, `HP_EE_START} << 1;
      end else begin
        nxt_s.mosi = 1'b0;
      end
    end else if (s_ff.st == HP_LOAD) begin
      nxt_s.wd = s_ff.wd + 21'h000001;
      if (s_ff.div == SCK_HALF - 5'h01) begin
        nxt_s.div = 5'h00;
        nxt_s.sck = !s_ff.sck; // RL15
        rise = !s_ff.sck;
        fall = s_ff.sck;
      end else begin
        nxt_s.div = s_ff.div + 5'h01;
      end
      upd = pins.spi_edge_select ? rise : fall; // RL14
      smp = pins.spi_edge_select ? fall : rise; // RL14
      if (upd) begin
        nxt_s.mosi = s_ff.osr[15]; // RL20
        nxt_s.osr = {s_ff.osr[14:0], 1'b0};
      end
      if (smp) begin
        nxt_s.isr = byte_in; // RL20
        nxt_s.bitcnt = s_ff.bitcnt + 10'h001;
        if (s_ff.bitcnt[2:0] == 3'h7 && s_ff.bitcnt >= 10'(`HP_HDR_BITS - 1)) begin
          if (k < CFG_LEN) begin
            if (k != 7'(`HP_REG_STAT)) begin
              nxt_s.regs[k] = byte_in; // RL17
            end
          end else if (!j[0]) begin
            // indirect MAC entries follow the plain registers as index/data pairs
            nxt_s.mtmp = byte_in[`HP_MAC_IDX_W-1:0]; // RL18
          end else begin
            nxt_s.mac[s_ff.mtmp] = byte_in; // RL18
          end
        end
        finish = s_ff.bitcnt == TOTAL_BITS - 10'h001; // RL17
      end
      // watchdog: a stuck load still frees the host port in time
      if (s_ff.wd == LOAD_LIM || !pins.ext_rst_n) begin
        finish = 1'b1; // RL19
      end
      if (finish) begin
        nxt_s.st = HP_IDLE;
        nxt_s.cs_n = 1'b1; // RL17
        nxt_s.sck = 1'b0;
        nxt_s.mosi = 1'b0;
      end
    end

    // set wins over the clearing read
    nxt_s.regs[`HP_REG_STAT] = (do_clr ? 8'h00 : s_ff.regs[`HP_REG_STAT]) | evt_i; // RL7 RL8

    irq_act = |(nxt_s.regs[`HP_REG_STAT] & nxt_s.regs[`HP_REG_MASK]); // RL6
    nxt_s.irq_n = !irq_act; // RL6
    nxt_s.irq_oe = irq_act || nxt_s.regs[`HP_REG_CTRL][`HP_CTRL_IDLE_DRV]; // RL10 RL11
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_ff <= '0; // RL11
      s_ff.irq_n <= 1'b1;
      s_ff.cs_n <= 1'b1;
      s_ff.boot <= 1'b1; // RL13
      s_ff.ext_rst_d <= 1'b1;
      s_ff.st <= HP_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pins.d_dev = s_ff.rd_data;
  assign pins.d_dev_oe = s_ff.d_oe;
  assign pins.irq_n_o = s_ff.irq_n;
  assign pins.irq_oe = s_ff.irq_oe;
  assign pins.spi_cs_n = s_ff.cs_n;
  assign pins.eeprom_clock = s_ff.sck;
  assign pins.mosi = s_ff.mosi;
  assign load_busy_o = s_ff.st == HP_LOAD;
  assign irq_o = !s_ff.irq_n;

endmodule

// ### logic/hp_host.sv
`timescale 1ns/100ps
`include "hp_regs.svh"
module hp_host
  import hp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  hp_if.host pins,
  input wire logic [7:0] u_addr,
  input wire logic [7:0] u_wdata,
  input wire logic u_wr,
  input wire logic u_rd,
  output logic [7:0] u_rdata
);

  localparam logic [2:0] STRB_LAST = 3'(`HC_STROBE_CYC - 1);

  hp_host_t s_ff;
  hp_host_t nxt_s;
  logic sep_mode;
  logic rise;
  logic fall;
  logic smp;
  logic upd;
  logic [9:0] dbit;
  logic [7:0] cur;

  always_comb begin
    nxt_s = s_ff;
    sep_mode = pins.bus_mode_select == `HP_MODE_SEP;
    nxt_s.u_rdata = 8'h00;
    if (u_wr) begin
      case (u_addr)
        `HC_REG_ADDR: nxt_s.addr = u_wdata;
        `HC_REG_WDATA: nxt_s.wdata = u_wdata;
        `HC_REG_PINS: nxt_s.pins = u_wdata[4:0];
        `HC_REG_GO: begin
          if (s_ff.st == HC_IDLE) begin
            nxt_s.st = HC_SETUP;
            nxt_s.is_rd = u_wdata[0];
          end
        end
        default: begin
          if (u_addr[7:4] == `HC_IMG_BASE >> 4) begin
            nxt_s.img[u_addr[3:0]] = u_wdata;
          end
        end
      endcase
    end
    if (u_rd) begin
      case (u_addr)
        `HC_REG_ADDR: nxt_s.u_rdata = s_ff.addr;
        `HC_REG_WDATA: nxt_s.u_rdata = s_ff.wdata;
        `HC_REG_STAT: nxt_s.u_rdata = {6'h00, !pins.irq_n_o && pins.irq_oe, s_ff.st != HC_IDLE};
        `HC_REG_RDATA: nxt_s.u_rdata = s_ff.rdata;
        `HC_REG_PINS: nxt_s.u_rdata = {3'h0, s_ff.pins};
        default: begin
          if (u_addr[7:4] == `HC_IMG_BASE >> 4) begin
            nxt_s.u_rdata = s_ff.img[u_addr[3:0]];
          end
        end
      endcase
    end

    // host bus cycle: chip select wraps the strobe by one cycle each side
    case (s_ff.st)
      HC_SETUP: begin
        nxt_s.cs_n = 1'b0; // RL5
        nxt_s.d_oe = !s_ff.is_rd;
        nxt_s.rw = s_ff.is_rd; // RL2
        nxt_s.st = HC_STRB;
        nxt_s.cnt = 3'h0;
      end
      HC_STRB: begin
        nxt_s.rd_n = !(sep_mode && s_ff.is_rd); // RL1
        nxt_s.wr_n = !(sep_mode && !s_ff.is_rd); // RL1
        nxt_s.ds_n = sep_mode; // RL2
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.cnt == STRB_LAST) begin
          // an undriven bus reads back inverted, so stale data never looks valid
          nxt_s.rdata = pins.d_dev_oe ? pins.d_dev : ~pins.d_dev;
          nxt_s.rd_n = 1'b1;
          nxt_s.wr_n = 1'b1;
          nxt_s.ds_n = 1'b1;
          nxt_s.st = HC_HOLD;
        end
      end
      HC_HOLD: begin
        nxt_s.cs_n = 1'b1;
        nxt_s.d_oe = 1'b0;
        nxt_s.st = HC_IDLE;
      end
      default: begin
      end
    endcase

    // serial eeprom responder; pins are sampled directly in sys_clk
    nxt_s.sck_d = pins.eeprom_clock;
    rise = pins.eeprom_clock && !s_ff.sck_d;
    fall = !pins.eeprom_clock && s_ff.sck_d;
    smp = pins.spi_edge_select ? fall : rise; // RL14
    upd = pins.spi_edge_select ? rise : fall; // RL14
    dbit = s_ff.bcnt - 10'(`HP_HDR_BITS);
    cur = s_ff.img[dbit[6:3]];
    if (pins.spi_cs_n) begin
      nxt_s.bcnt = 10'h000;
      nxt_s.cmd_ok = 1'b0;
      nxt_s.miso = 1'b0;
    end else begin
      if (smp) begin
        nxt_s.ish = {s_ff.ish[6:0], pins.mosi}; // RL20
        nxt_s.bcnt = s_ff.bcnt + 10'h001;
        if (s_ff.bcnt == 10'h007) begin
          nxt_s.cmd_ok = ({s_ff.ish[6:0], pins.mosi} & `HP_EE_READ_MASK) == `HP_EE_READ; // RL16
        end
      end
      if (upd && s_ff.cmd_ok && s_ff.bcnt >= 10'(`HP_HDR_BITS)) begin
        nxt_s.miso = cur[3'h7 - dbit[2:0]]; // RL20
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_ff <= '0;
      s_ff.st <= HC_IDLE;
      s_ff.pins <= `HC_PINS_RST;
      s_ff.cs_n <= 1'b1;
      s_ff.rd_n <= 1'b1;
      s_ff.wr_n <= 1'b1;
      s_ff.ds_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign u_rdata = s_ff.u_rdata;
  assign pins.cs_n = s_ff.cs_n;
  assign pins.rd_n = s_ff.rd_n;
  assign pins.wr_n = s_ff.wr_n;
  assign pins.data_strobe_n = s_ff.ds_n;
  assign pins.rd_wr = s_ff.rw;
  assign pins.addr = s_ff.addr;
  assign pins.d_host = s_ff.wdata;
  assign pins.d_host_oe = s_ff.d_oe;
  assign pins.bus_mode_select = s_ff.pins[1:0];
  assign pins.hardware_mode_pin = s_ff.pins[2];
  assign pins.spi_edge_select = s_ff.pins[3];
  assign pins.ext_rst_n = s_ff.pins[4];
  assign pins.miso = s_ff.miso;

endmodule

// ### bench/hp_link_assertions.sv
`timescale 1ns/100ps
module hp_link_assertions (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic data_strobe_n,
  input wire logic rd_wr,
  input wire logic d_dev_oe,
  input wire logic irq_n_o,
  input wire logic irq_oe,
  input wire logic [1:0] bus_mode_select,
  input wire logic hardware_mode_pin,
  input wire logic spi_edge_select,
  input wire logic ext_rst_n,
  input wire logic spi_cs_n,
  input wire logic eeprom_clock,
  input wire logic mosi
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic rd_q;
  logic [1:0] quiet_q;
  wire quiet = cs_n || hardware_mode_pin || bus_mode_select[1] ||
    (bus_mode_select == 2'b00 && rd_n) || (bus_mode_select == 2'b01 && data_strobe_n);
  // a read is only a read with select low and the strobe of the strapped mode
  always_ff @(posedge sys_clk) begin
    rd_q <= !cs_n && !hardware_mode_pin && ((bus_mode_select == 2'b00 && !rd_n) ||
      (bus_mode_select == 2'b01 && !data_strobe_n && rd_wr));
    quiet_q <= {quiet_q[0], quiet};
  end
  rd_oe_cause_a: assert property (
    $rose(d_dev_oe) |-> rd_q) else $error("data driven without a read");
  // two quiet cycles of slack: the drive stands one cycle past the strobe
  stray_drive_a: assert property (
    quiet && quiet_q == 2'b11 |-> !d_dev_oe) else $error("data driven while idle");
  load_no_drive_a: assert property (
    !spi_cs_n |-> !d_dev_oe) else $error("data driven during load");
  irq_driven_a: assert property (
    !irq_n_o |-> irq_oe) else $error("interrupt low while floating");
  irq_reset_a: assert property (
    $past(sys_rst) |-> !irq_oe) else $error("interrupt driven after reset");
  sck_high_a: assert property (
    $rose(eeprom_clock) |-> eeprom_clock[*8] ##1 eeprom_clock[*4] ##1 !eeprom_clock)
    else $error("eeprom clock high phase wrong");
  sck_idle_a: assert property (
    spi_cs_n && $past(spi_cs_n) |-> !eeprom_clock) else $error("eeprom clock outside frame");
  load_start_a: assert property (
    $rose(ext_rst_n) && bus_mode_select == 2'b10 && !hardware_mode_pin |-> ##[1:3] !spi_cs_n)
    else $error("load did not start");
  mosi_fall_a: assert property (
    !spi_edge_select && !spi_cs_n && eeprom_clock && $past(eeprom_clock) |-> $stable(mosi))
    else $error("mosi moved in high phase");
  mosi_rise_a: assert property (
    spi_edge_select && !spi_cs_n && !$past(spi_cs_n) && !eeprom_clock && !$past(eeprom_clock)
    |-> $stable(mosi)) else $error("mosi moved in low phase");
endmodule

// ### bench/host_port_and_eeprom_loader_tb.sv
`timescale 1ns/100ps
`include "hp_regs.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module host_port_and_eeprom_loader_tb;
  import hp_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic [7:0] evt_i = 0;
  logic [7:0] u_addr = 0;
  logic [7:0] u_wdata = 0;
  logic u_wr = 0;
  logic u_rd = 0;
  logic [7:0] u_rdata;
  logic load_busy_o;
  logic irq_o;
  logic [7:0] img [16];
  int fail_count = 0;
  int comparisons = 0;
  always #2.5 sys_clk = ~sys_clk;
  hp_if pins_if();
  // shortened limit keeps the run short; the full load still fits
  hp_dev #(.LOAD_LIMIT_CYC(20000)) hp_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .pins(pins_if), .evt_i(evt_i), .load_busy_o(load_busy_o), .irq_o(irq_o));
  hp_host hp_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins_if),
    .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata));
  hp_link_assertions hp_link_assertions_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cs_n(pins_if.cs_n), .rd_n(pins_if.rd_n), .data_strobe_n(pins_if.data_strobe_n),
    .rd_wr(pins_if.rd_wr), .d_dev_oe(pins_if.d_dev_oe), .irq_n_o(pins_if.irq_n_o),
    .irq_oe(pins_if.irq_oe), .bus_mode_select(pins_if.bus_mode_select),
    .hardware_mode_pin(pins_if.hardware_mode_pin), .spi_edge_select(pins_if.spi_edge_select),
    .ext_rst_n(pins_if.ext_rst_n), .spi_cs_n(pins_if.spi_cs_n),
    .eeprom_clock(pins_if.eeprom_clock), .mosi(pins_if.mosi));
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge sys_clk);
    u_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge sys_clk);
    u_rd <= 1'b0;
    #1 d = u_rdata;
  endtask
  task automatic wait_idle;
    logic [7:0] s;
    int n;
    for (n = 0; n < 50; n++) begin
      hrd(`HC_REG_STAT, s);
      if (s[0] === 1'b0) break;
    end
    if (n == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    hwr(`HC_REG_ADDR, a);
    hwr(`HC_REG_WDATA, d);
    hwr(`HC_REG_GO, 8'h00);
    wait_idle();
  endtask
  task automatic drd(input logic [7:0] a, output logic [7:0] d);
    hwr(`HC_REG_ADDR, a);
    hwr(`HC_REG_GO, 8'h01);
    wait_idle();
    hrd(`HC_REG_RDATA, d);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge sys_clk);
    evt_i <= e;
    @(posedge sys_clk);
    evt_i <= 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] e;
    int n;
    void'($urandom(32'h8238));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("irq_oe", 1'b0, pins_if.irq_oe)
    `CHK("spi_cs_n", 1'b1, pins_if.spi_cs_n)
    for (int k = 0; k < 8; k++) begin
      hwr(`HC_REG_PINS, 8'({3'b100, k[0] ? `HP_MODE_DS : `HP_MODE_SEP}));
      a = 8'h05 + 8'($urandom_range(250));
      d = 8'($urandom);
      if (k < 2) a = 8'hFF;
      dwr(a, d);
      drd(a, r);
      `CHK("plain reg", d, r)
    end
    // hardware mode must leave the register untouched
    dwr(8'h20, 8'h5A);
    hwr(`HC_REG_PINS, 8'h14);
    dwr(8'h20, 8'hA5);
    hwr(`HC_REG_PINS, 8'h10);
    drd(8'h20, r);
    `CHK("hw mode write", 8'h5A, r)
    e = 8'($urandom_range(255, 1));
    pulse(e);
    `CHK("irq masked", 1'b0, irq_o)
    drd(`HP_REG_STAT, r);
    `CHK("status", e, r)
    drd(`HP_REG_STAT, r);
    `CHK("status cleared", 8'h00, r)
    dwr(`HP_REG_CTRL, 8'h01);
    `CHK("irq idle drive", 2'b11, {pins_if.irq_oe, pins_if.irq_n_o})
    dwr(`HP_REG_MASK, e);
    pulse(e);
    `CHK("irq pin", 3'b110, {irq_o, pins_if.irq_oe, pins_if.irq_n_o})
    drd(`HP_REG_STAT, r);
    `CHK("irq after clear", 1'b0, irq_o)
    dwr(`HP_REG_CTRL, 8'h00);
    `CHK("irq float", 1'b0, pins_if.irq_oe)
    // the event lands exactly on the edge where the read strobe ends and clears
    hwr(`HC_REG_ADDR, `HP_REG_STAT);
    hwr(`HC_REG_GO, 8'h01);
    repeat (5) @(posedge sys_clk);
    evt_i <= e;
    @(posedge sys_clk);
    evt_i <= 8'h00;
    wait_idle();
    hrd(`HC_REG_RDATA, r);
    `CHK("status before event", 8'h00, r)
    drd(`HP_REG_STAT, r);
    `CHK("event in read", e, r)
    dwr(`HP_REG_STAT, 8'hFF);
    drd(`HP_REG_STAT, r);
    `CHK("status write", 8'h00, r)
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 16; i++) begin
        img[i] = 8'($urandom);
        hwr(8'(`HC_IMG_BASE + i), img[i]);
      end
      d = 8'($urandom);
      dwr(8'h80, d);
      hwr(`HC_REG_PINS, 8'({1'b0, k[0], 1'b0, `HP_MODE_EEP}));
      hwr(`HC_REG_PINS, 8'({1'b1, k[0], 1'b0, `HP_MODE_EEP}));
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("load busy", 1'b1, load_busy_o)
      // straps back to a host mode so only the load itself can block these
      hwr(`HC_REG_PINS, 8'({1'b1, k[0], 1'b0, `HP_MODE_SEP}));
      dwr(8'h80, ~d);
      drd(8'h80, r);
      for (n = 0; n < 20000; n++) begin
        @(posedge sys_clk);
        if (load_busy_o === 1'b0) break;
      end
      if (n == 20000) begin
        fail_count++;
        end_of_test();
      end
      hwr(`HC_REG_PINS, 8'h10);
      drd(8'h05, r);
      `CHK("config byte", img[5], r)
      drd(8'h3F, r);
      `CHK("last config", img[15], r)
      dwr(`HP_REG_MIDX, 8'(img[6][2:0]));
      drd(`HP_REG_MDATA, r);
      `CHK("mac entry", img[7], r)
      dwr(`HP_REG_MDATA, ~img[7]);
      drd(`HP_REG_MDATA, r);
      `CHK("mac write", ~img[7], r)
      drd(8'h80, r);
      `CHK("write in load", d, r)
    end
    end_of_test();
  end
endmodule
